// ---- logic/cscfg_map.svh ----
// Purpose: command codes and field positions of the stack and options words, and the fault counter width
// Assumes: 16-bit word commands
// Notes: defaults come from non-volatile memory ports at reset release, stack setup from pin value when override set
`ifndef CSCFG_MAP_SVH
`define CSCFG_MAP_SVH
`define CSCFG_CMD_STACK 8'hEC
`define CSCFG_CMD_MISC 8'hED
`define CSCFG_STK_CNT_HI 3
`define CSCFG_MISC_PEC 15
`define CSCFG_MISC_BOOT_SD 14
`define CSCFG_MISC_BOOT_FLT 13
`define CSCFG_MISC_RST_ROLE 12
`define CSCFG_MISC_PULLUP_N 3
`define CSCFG_MISC_FLT_CLR 2
`define CSCFG_MISC_RES_HI 1
`define CSCFG_FAULT_COUNTER_CLEAR_MODE_W 8
`endif

// ---- logic/cscfg_pkg.sv ----
// Purpose: types of the converter stack config block
// Assumes: nothing
// Notes: none
package cscfg_pkg;
  typedef enum logic [1:0] {CSCFG_ONE, CSCFG_TWO, CSCFG_THREE, CSCFG_FOUR} cscfg_phase_type;
  typedef enum logic [1:0] {CSCFG_R12, CSCFG_R10, CSCFG_R8, CSCFG_R6} cscfg_res_type;
endpackage

// ---- logic/cscfg_converter_stack_misc_config.sv ----
// Purpose: stack setup and misc options command registers
// Assumes: host side decodes pmbus frames into cmd/wr/rd strobes with pec_present flag
// Notes: nvm values are applied on the first clock after reset release
// How it works
// - low nibble codes 0..3 select one to four phases
// - other nibble codes refused, invalid-data flag pulsed to host
// - bits 15:4 of stack setup read zero and ignore writes
// - stack setup writes accepted only while conversion disabled
// - bit 15 set rejects transactions lacking pec
// - bit 14 set reloads boot voltage on shutdown
// - bit 13 with retry reloads boot voltage on fault restart
// - bit 12 picks power-good or active-low reset pin role
// - in reset role pullup on when bit 3 is zero
// - fault-free cycle decrements counter, or clears it when bit 2 set
// - bits 1:0 choose 12, 10, 8 or 6 bit telemetry
// - power-good held low while conversion disabled
// - stack setup loaded from nvm or pin value per override bit
`timescale 1ns/1ps
`include "cscfg_map.svh"
module cscfg_converter_stack_misc_config
  import cscfg_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [7:0] cmd_code,
  input wire logic cmd_wr,
  input wire logic cmd_rd,
  input wire logic pec_present,
  input wire logic [15:0] wr_data,
  output logic [15:0] rd_data,
  output logic cmd_invalid_data,
  output logic cmd_invalid_pec,
  input wire logic [15:0] nvm_stack,
  input wire logic [15:0] nvm_misc,
  input wire logic [3:0] pin_stack,
  input wire logic stack_pin_override,
  input wire logic restore_cmd,
  input wire logic conversion_en,
  input wire logic power_ok,
  input wire logic op_shutdown,
  input wire logic fault_restart,
  input wire logic fault_retry_mode,
  input wire logic pwm_cycle,
  input wire logic fault_seen,
  output logic boot_reload,
  output logic [`CSCFG_FAULT_COUNTER_CLEAR_MODE_W-1:0] fault_count,
  input wire logic power_good_or_reset_pin_i,
  output logic power_good_or_reset_pin_o,
  output logic power_good_or_reset_pin_oe_n,
  output logic pin_pullup_en,
  output logic [1:0] phase_count,
  output logic [1:0] telemetry_resolution_select
);
  // ----------------------------------------
  // decode
  // ----------------------------------------
  function automatic logic stack_code_ok(input logic [3:0] c);
    stack_code_ok = (c[`CSCFG_STK_CNT_HI:2] == 2'h0);
  endfunction

  logic [3:0] stack_follower_count_ff;
  logic [15:0] misc_ff;
  logic init_ff;
  logic [`CSCFG_FAULT_COUNTER_CLEAR_MODE_W-1:0] flt_ff;
  logic [15:0] rd_ff;
  logic inv_ff;
  logic pecbad_ff;
  logic boot_ff;
  logic [3:0] nxt_stack;
  logic [15:0] nxt_misc;
  logic [`CSCFG_FAULT_COUNTER_CLEAR_MODE_W-1:0] nxt_flt;
  wire pec_reject = (cmd_wr | cmd_rd) & misc_ff[`CSCFG_MISC_PEC] & ~pec_present;
  wire wr_ok = cmd_wr & ~pec_reject;
  wire hit_stack = (cmd_code == `CSCFG_CMD_STACK);
  wire hit_misc = (cmd_code == `CSCFG_CMD_MISC);
  wire stack_refuse = wr_ok & hit_stack & (conversion_en | ~stack_code_ok(wr_data[3:0]));
  wire [3:0] load_stack = stack_pin_override ? pin_stack : nvm_stack[3:0];
  wire reset_role = misc_ff[`CSCFG_MISC_RST_ROLE];
  wire flt_full = (flt_ff == {`CSCFG_FAULT_COUNTER_CLEAR_MODE_W{1'b1}});
  // pin released only while running with power in range, same in either role
  wire pin_release = conversion_en & power_ok;
  wire [15:0] stack_word = {12'h000, stack_follower_count_ff};
  wire [15:0] rd_sel = hit_stack ? stack_word : (hit_misc ? misc_ff : 16'h0000);

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb
  begin
    nxt_stack = stack_follower_count_ff;
    if (!init_ff || restore_cmd)
      nxt_stack = load_stack;
    else if (wr_ok && hit_stack && !stack_refuse)
      nxt_stack = wr_data[3:0];
  end

  always_comb
  begin
    nxt_misc = misc_ff;
    if (!init_ff)
      nxt_misc = nvm_misc;
    else if (wr_ok && hit_misc)
      nxt_misc = wr_data;  // reserved bits kept as written; host writes zero
  end

  always_comb
  begin
    nxt_flt = flt_ff;
    if (pwm_cycle && fault_seen)
      nxt_flt = flt_full ? flt_ff : flt_ff + `CSCFG_FAULT_COUNTER_CLEAR_MODE_W'(1);  // holds at top, no wrap
    else if (pwm_cycle && misc_ff[`CSCFG_MISC_FLT_CLR])
      nxt_flt = '0;
    else if (pwm_cycle && flt_ff != '0)
      nxt_flt = flt_ff - `CSCFG_FAULT_COUNTER_CLEAR_MODE_W'(1);
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      init_ff <= 1'b0;
      stack_follower_count_ff <= 4'h0;
      misc_ff <= 16'h0000;
      flt_ff <= '0;
    end
    else
    begin
      init_ff <= 1'b1;
      stack_follower_count_ff <= nxt_stack;
      misc_ff <= nxt_misc;
      flt_ff <= nxt_flt;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      rd_ff <= 16'h0000;
      inv_ff <= 1'b0;
      pecbad_ff <= 1'b0;
      boot_ff <= 1'b0;
    end
    else
    begin
      rd_ff <= (cmd_rd && !pec_reject) ? rd_sel : rd_ff;
      inv_ff <= stack_refuse;
      pecbad_ff <= pec_reject;
      boot_ff <= (op_shutdown & misc_ff[`CSCFG_MISC_BOOT_SD])
        | (fault_restart & fault_retry_mode & misc_ff[`CSCFG_MISC_BOOT_FLT]);
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign rd_data = rd_ff;
  assign cmd_invalid_data = inv_ff;
  assign cmd_invalid_pec = pecbad_ff;
  assign boot_reload = boot_ff;
  assign fault_count = flt_ff;
  assign phase_count = stack_follower_count_ff[1:0];
  assign telemetry_resolution_select = misc_ff[`CSCFG_MISC_RES_HI:0];
  // pin drives low only; released level comes from pullup or external resistor
  assign power_good_or_reset_pin_o = 1'b0;
  assign power_good_or_reset_pin_oe_n = pin_release;
  assign pin_pullup_en = reset_role & ~misc_ff[`CSCFG_MISC_PULLUP_N];

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_stack_lock;
    @(posedge clk_sys) disable iff (!rstn)
    (init_ff && conversion_en && !restore_cmd) |=> $stable(stack_follower_count_ff);
  endproperty
  a_stack_lock: assert property (p_stack_lock) else $error("stack changed while running");

  property p_stack_valid;
    @(posedge clk_sys) disable iff (!rstn)
    (init_ff && wr_ok && hit_stack && !restore_cmd) |=> stack_follower_count_ff[3:2] == 2'h0
      || $stable(stack_follower_count_ff);
  endproperty
  a_stack_valid: assert property (p_stack_valid) else $error("bad stack code stored");

  property p_inv_flag;
    @(posedge clk_sys) disable iff (!rstn)
    (cmd_wr && !pec_reject && hit_stack && wr_data[3:2] != 2'h0) |=> cmd_invalid_data;
  endproperty
  a_inv_flag: assert property (p_inv_flag) else $error("invalid code not flagged");

  property p_stack_hi_zero;
    @(posedge clk_sys) disable iff (!rstn)
    (cmd_rd && hit_stack && !pec_reject) |=> rd_data[15:4] == 12'h000;
  endproperty
  a_stack_hi_zero: assert property (p_stack_hi_zero) else $error("stack upper bits nonzero");

  property p_pec;
    @(posedge clk_sys) disable iff (!rstn)
    (cmd_wr && misc_ff[15] && !pec_present && hit_misc && init_ff) |=> $stable(misc_ff)
      && cmd_invalid_pec;
  endproperty
  a_pec: assert property (p_pec) else $error("write without pec accepted");

  property p_boot;
    @(posedge clk_sys) disable iff (!rstn)
    (op_shutdown && misc_ff[14]) |=> boot_reload;
  endproperty
  a_boot: assert property (p_boot) else $error("boot reload missing");

  property p_boot_flt;
    @(posedge clk_sys) disable iff (!rstn)
    (!op_shutdown && fault_restart && (!fault_retry_mode || !misc_ff[13])) |=> !boot_reload;
  endproperty
  a_boot_flt: assert property (p_boot_flt) else $error("spurious boot reload");

  property p_pullup;
    @(posedge clk_sys) disable iff (!rstn)
    !misc_ff[12] |-> !pin_pullup_en;
  endproperty
  a_pullup: assert property (p_pullup) else $error("pullup on in power-good role");

  property p_power_good_output_low;
    @(posedge clk_sys) disable iff (!rstn)
    !conversion_en |-> !power_good_or_reset_pin_oe_n;
  endproperty
  a_power_good_output_low: assert property (p_power_good_output_low) else $error("pin released while disabled");

  property p_flt_clr;
    @(posedge clk_sys) disable iff (!rstn)
    (pwm_cycle && !fault_seen && misc_ff[2]) |=> fault_count == '0;
  endproperty
  a_flt_clr: assert property (p_flt_clr) else $error("fault counter not cleared");

  property p_flt_dec;
    @(posedge clk_sys) disable iff (!rstn)
    (pwm_cycle && !fault_seen && !misc_ff[`CSCFG_MISC_FLT_CLR] && fault_count != '0)
      |=> fault_count == $past(fault_count) - `CSCFG_FAULT_COUNTER_CLEAR_MODE_W'(1);
  endproperty
  a_flt_dec: assert property (p_flt_dec) else $error("counter not decremented");

  property p_pullup_on;
    @(posedge clk_sys) disable iff (!rstn)
    (reset_role && !misc_ff[`CSCFG_MISC_PULLUP_N]) |-> pin_pullup_en;
  endproperty
  a_pullup_on: assert property (p_pullup_on) else $error("reset pullup missing");

  property p_phase;
    @(posedge clk_sys) disable iff (!rstn)
    (init_ff && wr_ok && hit_stack && !stack_refuse && !restore_cmd)
      |=> phase_count == $past(wr_data[1:0]);
  endproperty
  a_phase: assert property (p_phase) else $error("phase count not taken");

  property p_res;
    @(posedge clk_sys) disable iff (!rstn)
    (init_ff && wr_ok && hit_misc) |=> telemetry_resolution_select == $past(wr_data[1:0]);
  endproperty
  a_res: assert property (p_res) else $error("resolution not taken");

  property p_restore;
    @(posedge clk_sys) disable iff (!rstn)
    (init_ff && restore_cmd)
      |=> stack_follower_count_ff == $past(stack_pin_override ? pin_stack : nvm_stack[3:0]);
  endproperty
  a_restore: assert property (p_restore) else $error("restore value wrong");

  property p_init;
    @(posedge clk_sys) disable iff (!rstn)
    !init_ff |=> misc_ff == $past(nvm_misc);
  endproperty
  a_init: assert property (p_init) else $error("options not loaded at start");

  property p_pec_rd;
    @(posedge clk_sys) disable iff (!rstn)
    (cmd_rd && misc_ff[`CSCFG_MISC_PEC] && !pec_present)
      |=> cmd_invalid_pec && $stable(rd_data);
  endproperty
  a_pec_rd: assert property (p_pec_rd) else $error("read without pec served");

  property p_boot_off;
    @(posedge clk_sys) disable iff (!rstn)
    (op_shutdown && !misc_ff[`CSCFG_MISC_BOOT_SD] && !fault_restart) |=> !boot_reload;
  endproperty
  a_boot_off: assert property (p_boot_off) else $error("boot reload while off");

  property p_boot_flt_on;
    @(posedge clk_sys) disable iff (!rstn)
    (fault_restart && fault_retry_mode && misc_ff[`CSCFG_MISC_BOOT_FLT]) |=> boot_reload;
  endproperty
  a_boot_flt_on: assert property (p_boot_flt_on) else $error("fault reload missing");

  c_refuse: cover property (@(posedge clk_sys) disable iff (!rstn) stack_refuse);
  c_stack_wr: cover property (@(posedge clk_sys) disable iff (!rstn)
    wr_ok && hit_stack && !stack_refuse);
  c_pec_rej: cover property (@(posedge clk_sys) disable iff (!rstn) pec_reject);
  c_res6: cover property (@(posedge clk_sys) disable iff (!rstn)
    cscfg_res_type'(telemetry_resolution_select) == CSCFG_R6);
  c_pin_low: cover property (@(posedge clk_sys) disable iff (!rstn)
    reset_role && !power_good_or_reset_pin_i);
endmodule

// ---- verification/cscfg_host_model.sv ----
// Purpose: host model issuing word reads and writes
// Assumes: one access at a time, strobes one cycle
// Notes: write data is inverted once released
`timescale 1ns/1ps
`include "cscfg_map.svh"
module cscfg_host_model
(
  input wire logic clk_sys,
  output logic [7:0] cmd_code = 8'h00,
  output logic cmd_wr = 1'b0,
  output logic cmd_rd = 1'b0,
  output logic pec_present = 1'b0,
  output logic [15:0] wr_data = 16'h0000,
  input wire logic [15:0] rd_data,
  input wire logic cmd_invalid_data,
  input wire logic cmd_invalid_pec
);
  // ----------------
  // word access
  // ----------------
  task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d,
    input logic p, output logic [15:0] q, output logic [1:0] flg);
    logic [15:0] dw;
    dw = (c == `CSCFG_CMD_MISC) ? (d & 16'hF00F) : d;
    @(posedge clk_sys);
    cmd_code <= c;
    wr_data <= dw;
    pec_present <= p;
    cmd_wr <= w;
    cmd_rd <= !w;
    @(posedge clk_sys);
    cmd_wr <= 1'b0;
    cmd_rd <= 1'b0;
    wr_data <= ~dw;
    #1;
    q = rd_data;
    flg = {cmd_invalid_data, cmd_invalid_pec};
  endtask
endmodule

// ---- verification/testbench.sv ----
// Purpose: self-checking bench of the stack and options registers
// Assumes: host model performs every word access
// Notes: fault counter counts up on faulty cycles, a design choice
`timescale 1ns/1ps
`include "cscfg_map.svh"
module testbench;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] cmd_code;
  logic cmd_wr, cmd_rd, pec_present, cmd_invalid_data, cmd_invalid_pec;
  logic [15:0] wr_data, rd_data, q;
  logic [1:0] flg, phase_count, telemetry_resolution_select;
  logic [15:0] nvm_stack = 16'h0002;
  logic [15:0] nvm_misc = 16'h0007;
  logic [3:0] pin_stack = 4'h1;
  logic stack_pin_override = 1'b0, conversion_en = 1'b0, power_ok = 1'b1;
  logic fault_retry_mode = 1'b1, fault_seen = 1'b1;
  // event strobes: 0 shutdown, 1 fault restart, 2 pwm cycle, 3 restore
  logic [3:0] ev = 4'h0;
  wire op_shutdown = ev[0], fault_restart = ev[1], pwm_cycle = ev[2], restore_cmd = ev[3];
  logic boot_reload, power_good_or_reset_pin_o, power_good_or_reset_pin_oe_n, pin_pullup_en;
  logic [7:0] fault_count;
  logic [15:0] pv [3] = '{16'h1000, 16'h1008, 16'h0000};
  int miscompares = 0;
  int cmp_count = 0;
  always #2.5 clk_sys = ~clk_sys;
  cscfg_converter_stack_misc_config DUT (.clk_sys, .rstn, .cmd_code, .cmd_wr, .cmd_rd,
    .pec_present, .wr_data, .rd_data, .cmd_invalid_data, .cmd_invalid_pec, .nvm_stack,
    .nvm_misc, .pin_stack, .stack_pin_override, .restore_cmd, .conversion_en, .power_ok,
    .op_shutdown, .fault_restart, .fault_retry_mode, .pwm_cycle, .fault_seen, .boot_reload,
    .fault_count,
    // released pin reads high whether or not its pullup is enabled
    .power_good_or_reset_pin_i(power_good_or_reset_pin_oe_n | power_good_or_reset_pin_o),
    .power_good_or_reset_pin_o,
    .power_good_or_reset_pin_oe_n, .pin_pullup_en, .phase_count, .telemetry_resolution_select);
  cscfg_host_model u_host (.clk_sys, .cmd_code, .cmd_wr, .cmd_rd, .pec_present, .wr_data,
    .rd_data, .cmd_invalid_data, .cmd_invalid_pec);
  // ----------------
  // access and compare
  // ----------------
  task chk(input string n, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e)
    begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task wr(input logic [7:0] c, input logic [15:0] d);
    u_host.xfer(1'b1, c, d, 1'b1, q, flg);
  endtask
  task rd(input logic [7:0] c, input logic p);
    u_host.xfer(1'b0, c, 16'h0000, p, q, flg);
  endtask
  task pulse(input int k);
    @(posedge clk_sys) ev[k] <= 1'b1;
    @(posedge clk_sys) ev[k] <= 1'b0;
    #1;
  endtask
  task test_done;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // ----------------
  // tests
  // ----------------
  initial
  begin
    repeat (8) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rd(`CSCFG_CMD_STACK, 1'b1);
    chk("stack nvm", 16'h0002, q);
    rd(`CSCFG_CMD_MISC, 1'b1);
    chk("misc nvm", 16'h0007, q);
    for (int i = 0; i < 4; i++)
    begin
      wr(`CSCFG_CMD_STACK, 16'hFFF0 | 16'(i));
      chk("phases", 16'(i), {14'h0, phase_count});
      chk("code ok", 16'h0000, {15'h0, flg[1]});
      rd(`CSCFG_CMD_STACK, 1'b1);
      chk("stack rd", 16'(i), q);
    end
    wr(`CSCFG_CMD_STACK, 16'h0004);
    chk("bad code", 16'h0001, {15'h0, flg[1]});
    @(posedge clk_sys) conversion_en <= 1'b1;
    wr(`CSCFG_CMD_STACK, 16'h0001);
    chk("locked", 16'h0001, {15'h0, flg[1]});
    rd(`CSCFG_CMD_STACK, 1'b1);
    chk("stack kept", 16'h0003, q);
    chk("pg free", 16'h0001, {15'h0, power_good_or_reset_pin_oe_n});
    @(posedge clk_sys) conversion_en <= 1'b0;
    @(posedge clk_sys) #1;
    chk("pg low", 16'h0000, {15'h0, power_good_or_reset_pin_oe_n});
    chk("pg pin", 16'h0000, {15'h0, power_good_or_reset_pin_o});
    $display("stack test done");
    for (int i = 0; i < 4; i++)
    begin
      wr(`CSCFG_CMD_MISC, 16'(i));
      chk("res", 16'(i), {14'h0, telemetry_resolution_select});
    end
    for (int i = 0; i < 3; i++)
    begin
      wr(`CSCFG_CMD_MISC, pv[i]);
      chk("pullup", (i == 0) ? 16'h0001 : 16'h0000, {15'h0, pin_pullup_en});
    end
    wr(`CSCFG_CMD_MISC, 16'h8000);
    u_host.xfer(1'b1, `CSCFG_CMD_MISC, 16'h0003, 1'b0, q, flg);
    chk("pec wr", 16'h0001, {15'h0, flg[0]});
    rd(`CSCFG_CMD_MISC, 1'b0);
    chk("pec need", 16'h0001, {15'h0, flg[0]});
    rd(`CSCFG_CMD_MISC, 1'b1);
    chk("pec rd", 16'h8000, q);
    wr(`CSCFG_CMD_MISC, 16'h4000);
    rd(`CSCFG_CMD_MISC, 1'b0);
    chk("pec opt", 16'h4000, q);
    $display("misc test done");
    pulse(0);
    chk("boot sd", 16'h0001, {15'h0, boot_reload});
    wr(`CSCFG_CMD_MISC, 16'h0000);
    pulse(0);
    chk("no boot sd", 16'h0000, {15'h0, boot_reload});
    wr(`CSCFG_CMD_MISC, 16'h2000);
    pulse(1);
    chk("boot flt", 16'h0001, {15'h0, boot_reload});
    @(posedge clk_sys) fault_retry_mode <= 1'b0;
    pulse(1);
    chk("no boot flt", 16'h0000, {15'h0, boot_reload});
    repeat (3) pulse(2);
    @(posedge clk_sys) fault_seen <= 1'b0;
    pulse(2);
    chk("flt down", 16'h0002, {8'h0, fault_count});
    wr(`CSCFG_CMD_MISC, 16'h0004);
    pulse(2);
    chk("flt clear", 16'h0000, {8'h0, fault_count});
    @(posedge clk_sys) stack_pin_override <= 1'b1;
    pulse(3);
    rd(`CSCFG_CMD_STACK, 1'b1);
    chk("restore pin", 16'h0001, q);
    @(posedge clk_sys) stack_pin_override <= 1'b0;
    pulse(3);
    rd(`CSCFG_CMD_STACK, 1'b1);
    chk("restore nvm", 16'h0002, q);
    $display("event test done");
    test_done;
  end
  initial
  begin
    #20000;
    miscompares++;
    test_done;
  end
endmodule
